// [src/mode_map_cfg.svh]
// Summary of operation
// - mode pins captured into mode state at reset release
// - pull-up on background pin, pull-downs on mode pins during reset
// - three pins decode to seven modes; 110 forced to peripheral
// - expanded wide: ports A and B carry muxed 16-bit address/data
// - expanded narrow: port A address high plus 8-bit data, port B address low
// - single-chip: no bus, port E 1:0 input with pull-ups, rest tri-state inputs
// - reset enables port E pull-ups, port A and B pull-ups off
// - special expanded wide gives all port E control pins bus function
// - special narrow splits external 16-bit transfers high byte then low
// - special single-chip enters active debug monitor with no vector fetch
// - peripheral mode holds CPU inactive; mode left only through reset
// - elsewhere debug monitor must be enabled, then activated by command or instruction
// - active debug ROM occupies $FF00-$FFFF, registers $FF00-$FF06
// - debug accesses use idle bus cycles without halting the CPU
// - normal modes accept one write to each position register
// - mapping writes take effect by second cycle after the write
// - decode priority: debug ROM, registers, RAM, EEPROM, program, external
// - expanded modes: unclaimed addresses go to external memory
// - normal modes protect control bits; special modes allow wider writes
// - reset map: registers $0000, RAM $0800, EEPROM $0D00, program by mode
// - register position gives upper five address bits, 512-byte block
`ifndef MODE_MAP_CFG_SVH
`define MODE_MAP_CFG_SVH
`define REG_POS_RESET   5'h00
`define RAM_POS_RESET   5'h01
`define EE_POS_RESET    4'h0
`define REG_BLK_BITS    9
`define RAM_BLK_BITS    10
`define EE_LO           12'hd00
`define EE_HI           12'hfff
`define DBG_ROM_BASE    16'hff00
`define DBG_REG_LAST    16'hff06
`define MAP_DELAY       2
`endif

// [src/mode_map_pkg.sv]
package mode_map_pkg;
	typedef enum logic [2:0] {
		sp_single, sp_narrow, sp_periph, sp_wide,
		nm_single, nm_narrow, nm_reserved, nm_wide
	} mode_type;
	typedef enum logic [2:0] {
		sel_none, sel_dbg_rom, sel_regs, sel_ram, sel_eeprom, sel_prog, sel_ext
	} sel_type;
	typedef enum logic [1:0] {
		xfer_idle, xfer_high, xfer_low
	} xfer_type;
endpackage : mode_map_pkg

// [src/map_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface map_if;
	logic [4:0] reg_pos;
	logic [4:0] ram_pos;
	logic [3:0] ee_pos;
	logic       ee_on;
	logic       prog_on;
	logic       prog_hi;
	logic       dbg_active;
	logic       expanded;
	logic [15:0] addr;
	logic [2:0]  sel;
	modport ctrl (output reg_pos, ram_pos, ee_pos, ee_on, prog_on, prog_hi,
		dbg_active, expanded, addr, input sel);
	modport dec (input reg_pos, ram_pos, ee_pos, ee_on, prog_on, prog_hi,
		dbg_active, expanded, addr, output sel);
endinterface : map_if
`default_nettype wire

// [src/addr_decode.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mode_map_cfg.svh"
module addr_decode
	import mode_map_pkg::*;
(
	map_if.dec m
);
	sel_type s;
	always_comb
	begin
		s = sel_none;
		if (m.expanded)
			s = sel_ext;
		// lowest internal first so higher priority overrides
		if (m.prog_on && (m.addr[15] == m.prog_hi))
			s = sel_prog;
		if (m.ee_on && (m.addr[15:12] == m.ee_pos)
			&& (m.addr[11:0] >= `EE_LO) && (m.addr[11:0] <= `EE_HI))
			s = sel_eeprom;
		if (m.addr[15:11] == m.ram_pos && !m.addr[`RAM_BLK_BITS])
			s = sel_ram;
		// first 512 bytes of the 2-Kbyte block
		if (m.addr[15:11] == m.reg_pos && m.addr[10:`REG_BLK_BITS] == 2'h0)
			s = sel_regs;
		// debug ROM replaces vectors while active
		if (m.dbg_active && m.addr >= `DBG_ROM_BASE)
			s = sel_dbg_rom;
	end
	assign m.sel = s;
endmodule : addr_decode
`default_nettype wire

// [src/mode_map.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mode_map_cfg.svh"
module mode_map
	import mode_map_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        background_pin_i,
	input  wire logic        mode_select_b_pin_i,
	input  wire logic        mode_select_a_pin_i,
	input  wire logic        debug_enable_cmd_i,
	input  wire logic        debug_activate_cmd_i,
	input  wire logic        enter_debug_instruction_i,
	input  wire logic        debug_exit_i,
	input  wire logic        pos_wr_i,
	input  wire logic [1:0]  pos_sel_i,
	input  wire logic [7:0]  pos_data_i,
	input  wire logic        bus_valid_i,
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        bus_wide_i,
	input  wire logic        bus_idle_i,
	input  wire logic        dbg_req_i,
	output logic [2:0]       mode_o,
	output logic             special_mode_n_bit_o,
	output logic             expanded_o,
	output logic             wide_o,
	output logic             single_chip_o,
	output logic             peripheral_o,
	output logic             cpu_run_o,
	output logic             vector_fetch_o,
	output logic             debug_enabled_o,
	output logic             debug_monitor_mode_o,
	output logic             background_pin_pullup_o,
	output logic             mode_pulldown_o,
	output logic             porte_pullup_o,
	output logic             portab_pullup_o,
	output logic             porte_bus_ctrl_o,
	output logic             porta_addr_hi_o,
	output logic             porta_data_o,
	output logic             portb_addr_lo_o,
	output logic             portb_data_o,
	output logic             ext_cycle_o,
	output logic             ext_high_byte_o,
	output logic [2:0]       sel_o,
	output logic             dbg_grant_o,
	output logic             write_protect_o,
	output logic [4:0]       register_block_position_o,
	output logic [4:0]       ram_position_o,
	output logic [3:0]       eeprom_position_o
);
	typedef struct packed {
		logic       in_rst;
		mode_type   mode;
		logic       dbg_en;
		logic       dbg_act;
		logic       vec;
		logic [4:0] reg_pos;
		logic [4:0] ram_pos;
		logic [3:0] ee_pos;
		logic [2:0] wrote;
		logic [4:0] reg_pend;
		logic [4:0] ram_pend;
		logic [3:0] ee_pend;
		logic [2:0] pend;
		xfer_type   xfer;
		logic [2:0] sel;
		logic       grant;
	} state_type;

	// power-up map and normal single-chip flags until the pins are latched
	localparam state_type st_reset = '{
		in_rst:   1'b1,
		mode:     nm_single,
		dbg_en:   1'b0,
		dbg_act:  1'b0,
		vec:      1'b0,
		reg_pos:  `REG_POS_RESET,
		ram_pos:  `RAM_POS_RESET,
		ee_pos:   `EE_POS_RESET,
		wrote:    3'h0,
		reg_pend: 5'h00,
		ram_pend: 5'h00,
		ee_pend:  4'h0,
		pend:     3'h0,
		xfer:     xfer_idle,
		sel:      3'h0,
		grant:    1'b0
	};

	state_type st;
	state_type next_st;
	map_if     mif();

	function automatic logic is_special(input mode_type md);
		is_special = (md == sp_single) || (md == sp_narrow) || (md == sp_periph)
			|| (md == sp_wide);
	endfunction : is_special

	function automatic logic is_expanded(input mode_type md);
		is_expanded = (md == sp_narrow) || (md == sp_wide) || (md == nm_narrow)
			|| (md == nm_wide);
	endfunction : is_expanded

	function automatic logic is_wide(input mode_type md);
		is_wide = (md == sp_wide) || (md == nm_wide);
	endfunction : is_wide

	function automatic logic is_single(input mode_type md);
		is_single = (md == sp_single) || (md == nm_single);
	endfunction : is_single

	// register block and ram positions both sit in the top five data bits
	function automatic logic [4:0] pos5(input logic [7:0] d);
		pos5 = d[7:3];
	endfunction : pos5

	assign mif.reg_pos    = st.reg_pos;
	assign mif.ram_pos    = st.ram_pos;
	assign mif.ee_pos     = st.ee_pos;
	// eeprom array forced on in every mode; there is no enable control
	assign mif.ee_on      = 1'b1;
	// program memory disabled in expanded modes, upper half in single-chip
	assign mif.prog_on    = is_single(st.mode);
	assign mif.prog_hi    = 1'b1;
	assign mif.dbg_active = st.dbg_act;
	assign mif.expanded   = is_expanded(st.mode);
	assign mif.addr       = bus_addr_i;

	addr_decode u_dec (
		.m (mif.dec)
	);

	always_comb
	begin
		next_st = st;
		next_st.in_rst = sys_rst_i;
		next_st.vec = 1'b0;
		next_st.grant = 1'b0;
		next_st.sel = bus_valid_i ? mif.sel : 3'h0;
		if (sys_rst_i)
		begin
			next_st.dbg_en = 1'b0;
			next_st.dbg_act = 1'b0;
			next_st.reg_pos = `REG_POS_RESET;
			next_st.ram_pos = `RAM_POS_RESET;
			next_st.ee_pos = `EE_POS_RESET;
			next_st.wrote = 3'h0;
			next_st.pend = 3'h0;
			next_st.xfer = xfer_idle;
			next_st.sel = 3'h0;
		end
		else
		begin
			if (st.in_rst)
			begin
				// latch pins on reset release; decode
				next_st.mode = mode_type'({background_pin_i, mode_select_b_pin_i,
					mode_select_a_pin_i});
				if (next_st.mode == nm_reserved)
					next_st.mode = sp_periph;
				// straight into active monitor, no vector fetch
				if (next_st.mode == sp_single)
				begin
					next_st.dbg_en = 1'b1;
					next_st.dbg_act = 1'b1;
				end
				// no fetch in peripheral mode either
				next_st.vec = (next_st.mode != sp_single) && (next_st.mode != sp_periph);
			end
			// mode never changes after the latch; CPU held in peripheral mode
			else if (st.mode != sp_periph)
			begin
				if (debug_enable_cmd_i)
					next_st.dbg_en = 1'b1;
				if (st.dbg_en && (debug_activate_cmd_i || enter_debug_instruction_i))
					next_st.dbg_act = 1'b1;
				else if (debug_exit_i)
					next_st.dbg_act = 1'b0;
			end
			// staged writes land on the second cycle
			// decoder reads st positions, so the new map is live one edge after staging
			if (st.pend[0])
				next_st.reg_pos = st.reg_pend;
			if (st.pend[1])
				next_st.ram_pos = st.ram_pend;
			if (st.pend[2])
				next_st.ee_pos = st.ee_pend;
			next_st.pend = 3'h0;
			// write once in normal modes; anytime in special
			if (pos_wr_i && pos_sel_i != 2'h3
				&& (is_special(st.mode) || !st.wrote[pos_sel_i]))
			begin
				next_st.wrote[pos_sel_i] = 1'b1;
				next_st.pend[pos_sel_i] = 1'b1;
				unique case (pos_sel_i)
					2'h0: next_st.reg_pend = pos5(pos_data_i);
					2'h1: next_st.ram_pend = pos5(pos_data_i);
					default: next_st.ee_pend = pos_data_i[7:4];
				endcase
			end
			// narrow special: high byte then low byte
			unique case (st.xfer)
				xfer_idle:
					if (bus_valid_i && bus_wide_i && mif.sel == sel_ext
						&& st.mode == sp_narrow)
						next_st.xfer = xfer_high;
				xfer_high: next_st.xfer = xfer_low;
				xfer_low:  next_st.xfer = xfer_idle;
				default:   next_st.xfer = xfer_idle;
			endcase
			// debug access granted only in idle bus cycles
			next_st.grant = dbg_req_i && bus_idle_i && st.dbg_en;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			st <= st_reset;
		else
			st <= next_st;
	end

	// registered outputs
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			mode_o <= 3'h4;
			special_mode_n_bit_o <= 1'b1;
			expanded_o <= 1'b0;
			wide_o <= 1'b0;
			single_chip_o <= 1'b1;
			peripheral_o <= 1'b0;
			cpu_run_o <= 1'b0;
			vector_fetch_o <= 1'b0;
			debug_enabled_o <= 1'b0;
			debug_monitor_mode_o <= 1'b0;
			background_pin_pullup_o <= 1'b1;
			mode_pulldown_o <= 1'b1;
			porte_pullup_o <= 1'b1;
			portab_pullup_o <= 1'b0;
			porte_bus_ctrl_o <= 1'b0;
			porta_addr_hi_o <= 1'b0;
			porta_data_o <= 1'b0;
			portb_addr_lo_o <= 1'b0;
			portb_data_o <= 1'b0;
			ext_cycle_o <= 1'b0;
			ext_high_byte_o <= 1'b0;
			sel_o <= 3'h0;
			dbg_grant_o <= 1'b0;
			write_protect_o <= 1'b1;
			register_block_position_o <= `REG_POS_RESET;
			ram_position_o <= `RAM_POS_RESET;
			eeprom_position_o <= `EE_POS_RESET;
		end
		else
		begin
			// decoded flags follow the latched mode
			mode_o <= next_st.mode;
			special_mode_n_bit_o <= !is_special(next_st.mode);
			expanded_o <= is_expanded(next_st.mode);
			wide_o <= is_wide(next_st.mode);
			single_chip_o <= is_single(next_st.mode);
			peripheral_o <= next_st.mode == sp_periph;
			// cpu held inactive in peripheral mode
			cpu_run_o <= next_st.mode != sp_periph;
			vector_fetch_o <= next_st.vec;
			debug_enabled_o <= next_st.dbg_en;
			debug_monitor_mode_o <= next_st.dbg_act;
			background_pin_pullup_o <= 1'b0;
			mode_pulldown_o <= 1'b0;
			porte_pullup_o <= 1'b1;
			portab_pullup_o <= 1'b0;
			// port E bus control in special wide; expanded modes generally
			porte_bus_ctrl_o <= is_expanded(next_st.mode);
			// port A address high with data, port B address low
			porta_addr_hi_o <= is_expanded(next_st.mode);
			porta_data_o <= is_expanded(next_st.mode);
			portb_addr_lo_o <= is_expanded(next_st.mode);
			// port B data only when wide; single-chip leaves all as gpio
			portb_data_o <= is_wide(next_st.mode);
			ext_cycle_o <= next_st.sel == sel_ext || next_st.xfer != xfer_idle;
			ext_high_byte_o <= next_st.xfer == xfer_high;
			sel_o <= next_st.sel;
			dbg_grant_o <= next_st.grant;
			write_protect_o <= !is_special(next_st.mode);
			// positions shown follow the map the decoder is using
			register_block_position_o <= next_st.reg_pos;
			ram_position_o <= next_st.ram_pos;
			eeprom_position_o <= next_st.ee_pos;
		end
	end
endmodule : mode_map
`default_nettype wire

// [testbench/mode_map_props.sv]
`timescale 1ns/10ps
`default_nettype none
module mode_map_props (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        pos_wr_i,
	input wire logic [1:0]  pos_sel_i,
	input wire logic        bus_valid_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic [2:0]  mode_o,
	input wire logic        special_mode_n_bit_o,
	input wire logic        expanded_o,
	input wire logic        wide_o,
	input wire logic        single_chip_o,
	input wire logic        peripheral_o,
	input wire logic        cpu_run_o,
	input wire logic        debug_monitor_mode_o,
	input wire logic        porte_bus_ctrl_o,
	input wire logic        ext_high_byte_o,
	input wire logic [2:0]  sel_o,
	input wire logic        write_protect_o,
	input wire logic [4:0]  ram_position_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_MODE_HOLD: assert property (
		!$past(sys_rst_i) && !$past(sys_rst_i, 2) && !$past(sys_rst_i, 3) |-> $stable(mode_o))
		else $error("mode moved after latch");
	AST_RESERVED: assert property (mode_o != 3'h6)
		else $error("reserved mode shown");
	AST_PERIPH: assert property (peripheral_o |-> !cpu_run_o && !debug_monitor_mode_o)
		else $error("cpu or debug alive in peripheral mode");
	AST_PERIPH_LOCK: assert property (peripheral_o |=> peripheral_o)
		else $error("peripheral mode left without reset");
	AST_SC_BUS: assert property (
		single_chip_o |-> !expanded_o && !porte_bus_ctrl_o && sel_o != 3'h6)
		else $error("bus activity in single-chip mode");
	AST_PROTECT: assert property (write_protect_o == special_mode_n_bit_o)
		else $error("protection does not follow mode");
	AST_SPLIT: assert property (
		ext_high_byte_o |-> !special_mode_n_bit_o && expanded_o && !wide_o)
		else $error("byte split outside special narrow");
	AST_POS_DELAY: assert property (
		$changed(ram_position_o) |-> $past(pos_wr_i, 2) && $past(pos_sel_i, 2) == 2'h1)
		else $error("ram position moved off schedule");
	AST_DBG_ROM: assert property (
		bus_valid_i && debug_monitor_mode_o && bus_addr_i[15:8] == 8'hff |=> sel_o == 3'h1)
		else $error("debug rom not selected");
	AST_IDLE_SEL: assert property (!bus_valid_i |=> sel_o == 3'h0)
		else $error("select without valid access");
endmodule : mode_map_props
bind mode_map mode_map_props u_props (.clk_i, .sys_rst_i, .pos_wr_i, .pos_sel_i,
	.bus_valid_i, .bus_addr_i, .mode_o, .special_mode_n_bit_o, .expanded_o, .wide_o,
	.single_chip_o, .peripheral_o, .cpu_run_o, .debug_monitor_mode_o, .porte_bus_ctrl_o,
	.ext_high_byte_o, .sel_o, .write_protect_o, .ram_position_o);
`default_nettype wire

// [testbench/ext_master.sv]
`timescale 1ns/10ps
`default_nettype none
module ext_master (
	input  wire logic       clk_i,
	input  wire logic       hb_i,
	input  wire logic       ec_i,
	input  wire logic [2:0] sel_i,
	output logic            valid_o,
	output logic [15:0]     addr_o,
	output logic            wide_o
);
	initial
	begin
		valid_o = 1'h0;
		addr_o = 16'h0;
		wide_o = 1'h0;
	end
	task automatic access(input logic [15:0] a, input logic w,
		output logic [2:0] s, output int hi, output int ec);
		hi = 0;
		ec = 0;
		valid_o = 1'h1;
		addr_o = a;
		wide_o = w;
		@(negedge clk_i);
		s = sel_i;
		// released lines show the inverse so stale values never pass
		valid_o = 1'h0;
		addr_o = ~a;
		wide_o = ~w;
		repeat (4)
		begin
			hi += hb_i;
			ec += ec_i;
			@(negedge clk_i);
		end
	endtask : access
endmodule : ext_master
`default_nettype wire

// [testbench/mode_map_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module mode_map_bench;
	import mode_map_pkg::*;
	logic clk_i, sys_rst_i, background_pin_i, mode_select_b_pin_i, mode_select_a_pin_i;
	logic debug_enable_cmd_i, debug_activate_cmd_i, enter_debug_instruction_i, pos_wr_i;
	logic bus_valid_i, bus_wide_i, special_mode_n_bit_o, expanded_o, wide_o, single_chip_o;
	logic peripheral_o, cpu_run_o, vector_fetch_o, debug_monitor_mode_o, background_pin_pullup_o;
	logic mode_pulldown_o, porte_pullup_o, portab_pullup_o, porte_bus_ctrl_o, dbg;
	logic porta_addr_hi_o, porta_data_o, portb_addr_lo_o, portb_data_o, ext_high_byte_o;
	logic write_protect_o, per, dbg_req_i, bus_idle_i, ext_cycle_o, dbg_grant_o, debug_enabled_o;
	logic [1:0] pos_sel_i;
	logic [7:0] pos_data_i;
	logic [15:0] bus_addr_i;
	logic [2:0] mode_o, sel_o, m;
	logic [4:0] register_block_position_o, ram_position_o, rp, mp;
	logic [3:0] eeprom_position_o, ep;
	int fails, num_checks;

	mode_map u_dut (.clk_i, .sys_rst_i, .background_pin_i, .mode_select_b_pin_i,
		.mode_select_a_pin_i, .debug_enable_cmd_i, .debug_activate_cmd_i,
		.enter_debug_instruction_i, .debug_exit_i(1'h0), .pos_wr_i, .pos_sel_i, .pos_data_i,
		.bus_valid_i, .bus_addr_i, .bus_wide_i, .bus_idle_i, .dbg_req_i, .mode_o,
		.special_mode_n_bit_o, .expanded_o, .wide_o, .single_chip_o, .peripheral_o,
		.cpu_run_o, .vector_fetch_o, .debug_enabled_o, .debug_monitor_mode_o,
		.background_pin_pullup_o, .mode_pulldown_o, .porte_pullup_o, .portab_pullup_o,
		.porte_bus_ctrl_o, .porta_addr_hi_o, .porta_data_o, .portb_addr_lo_o, .portb_data_o,
		.ext_cycle_o, .ext_high_byte_o, .sel_o, .dbg_grant_o, .write_protect_o,
		.register_block_position_o, .ram_position_o, .eeprom_position_o);
	ext_master u_bus (.clk_i, .hb_i(ext_high_byte_o), .ec_i(ext_cycle_o), .sel_i(sel_o),
		.valid_o(bus_valid_i), .addr_o(bus_addr_i), .wide_o(bus_wide_i));

	task automatic chk(string n, logic e, logic g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask : chk
	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	function automatic logic [2:0] exp_sel(logic [15:0] a);
		if (dbg && a[15:8] == 8'hff) return 3'h1;
		if (a[15:11] == rp && a[10:9] == 2'h0) return 3'h2;
		if (a[15:11] == mp && !a[10]) return 3'h3;
		if (a[15:12] == ep && a[11:8] >= 4'hd) return 3'h4;
		if (!m[0] && a[15]) return 3'h5;
		return m[0] ? 3'h6 : 3'h0;
	endfunction : exp_sel
	task automatic probe(logic [15:0] a, logic w);
		logic [2:0] s;
		logic sp;
		int hi;
		int ec;
		if (per) return;
		u_bus.access(a, w, s, hi, ec);
		sp = m == 3'h1 && w && exp_sel(a) == 3'h6;
		chk8("sel", {5'h0, exp_sel(a)}, {5'h0, s});
		chk("split", sp, hi == 1);
		chk8("ext cycles", 8'(exp_sel(a) == 3'h6) + 8'(sp), 8'(ec));
	endtask : probe
	task automatic decodes(int n);
		logic [15:0] r;
		r = 16'($urandom);
		foreach (r[i]) probe(16'h01ff << i, r[i]);
		repeat (n)
		begin
			r = 16'($urandom);
			case (r[1:0])
				2'h0: probe({rp, 2'h0, r[10:2]}, r[15]);
				2'h1: probe({mp, 1'h0, r[11:2]}, r[15]);
				2'h2: probe({ep, 4'hd, r[9:2]}, r[15]);
				default: probe(r, r[14]);
			endcase
		end
	endtask : decodes
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge clk_i);
		s = 1'h0;
		repeat (3) @(negedge clk_i);
	endtask : pulse
	task automatic pos_chk();
		chk8("reg pos", {3'h0, rp}, {3'h0, register_block_position_o});
		chk8("ram pos", {3'h0, mp}, {3'h0, ram_position_o});
		chk8("ee pos", {4'h0, ep}, {4'h0, eeprom_position_o});
	endtask : pos_chk
	task automatic boot(logic [2:0] pins);
		int vf;
		vf = 0;
		sys_rst_i = 1'h1;
		{background_pin_i, mode_select_b_pin_i, mode_select_a_pin_i} = pins;
		m = pins == 3'h6 ? 3'h2 : pins;
		per = m == 3'h2;
		{rp, mp, ep, dbg} = {5'h0, 5'h1, 4'h0, m == 3'h0};
		repeat (12) @(negedge clk_i);
		chk("background_pin pullup", 1'h1, background_pin_pullup_o);
		chk("mode pulldown", 1'h1, mode_pulldown_o);
		sys_rst_i = 1'h0;
		repeat (6)
		begin
			@(negedge clk_i);
			vf += vector_fetch_o;
		end
		{background_pin_i, mode_select_b_pin_i, mode_select_a_pin_i} = ~pins;
		@(negedge clk_i);
		chk("vector fetch", m != 3'h0 && !per, vf == 1);
		chk8("mode", {5'h0, m}, {5'h0, mode_o});
		chk("special n", m[2], special_mode_n_bit_o);
		chk("peripheral", per, peripheral_o);
		chk("cpu run", !per, cpu_run_o);
		chk("debug at boot", m == 3'h0, debug_monitor_mode_o);
		chk("porte pullup", 1'h1, porte_pullup_o);
		chk("portab pullup", 1'h0, portab_pullup_o);
		chk("protect", m[2], write_protect_o);
		if (m == 3'h3) chk("porte bus", 1'h1, porte_bus_ctrl_o);
		if (!per)
		begin
			chk("expanded", m[0], expanded_o);
			chk("single", !m[0], single_chip_o);
			chk("wide", m[1] & m[0], wide_o);
			chk("portb data", m[1] & m[0], portb_data_o);
			chk("porta addr", m[0], porta_addr_hi_o);
			chk("porta data", m[0], porta_data_o);
			chk("portb addr", m[0], portb_addr_lo_o);
		end
		pos_chk();
	endtask : boot
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	initial
	begin
		{debug_enable_cmd_i, debug_activate_cmd_i, enter_debug_instruction_i, pos_wr_i} = 4'h0;
		{pos_sel_i, pos_data_i, sys_rst_i} = 11'h1;
		{dbg_req_i, bus_idle_i} = 2'h0;
		{background_pin_i, mode_select_b_pin_i, mode_select_a_pin_i} = 3'h4;
		fails = 0;
		num_checks = 0;
		void'($urandom(47407));
		for (int i = 0; i < 8; i++)
		begin
			boot(3'(i));
			decodes(10);
			if (m != 3'h0)
			begin
				pulse(debug_activate_cmd_i);
				chk("active unenabled", 1'h0, debug_monitor_mode_o);
				pulse(debug_enable_cmd_i);
				if (m[0]) pulse(enter_debug_instruction_i);
				else pulse(debug_activate_cmd_i);
				chk("active", !per, debug_monitor_mode_o);
				dbg = !per;
			end
			chk("debug enabled", dbg, debug_enabled_o);
			for (int j = 0; j < 4; j++)
			begin
				{dbg_req_i, bus_idle_i} = 2'(j);
				@(negedge clk_i);
				chk("grant", j == 3 && dbg, dbg_grant_o);
			end
			{dbg_req_i, bus_idle_i} = 2'h0;
			probe(16'hff06, 1'h0);
			// every register gets two writes, then the ignored select
			for (int k = 0; k < 8; k++)
			begin
				pos_wr_i = 1'h1;
				pos_sel_i = 2'(k >> 1);
				pos_data_i = 8'($urandom);
				@(negedge clk_i);
				pos_wr_i = 1'h0;
				repeat (2) @(negedge clk_i);
				if (k < 6 && (!m[2] || !k[0]))
					case (k >> 1)
						0: rp = pos_data_i[7:3];
						1: mp = pos_data_i[7:3];
						default: ep = pos_data_i[7:4];
					endcase
				pos_chk();
			end
			decodes(10);
		end
		tally_and_finish();
	end
endmodule : mode_map_bench
`default_nettype wire
